// file: design/atacx_pkg.sv
/*
 package for the ata idle and read command executor: register map,
 opcodes, status bits, state encoding, timing constants and carriers.
 assumes a 100 MHz aclk.
*/
package atacx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FEATURE = 8'h01;
  localparam logic [7:0] IDX_COUNT = 8'h02;
  localparam logic [7:0] IDX_SECTOR = 8'h03;
  localparam logic [7:0] IDX_TRK_LO = 8'h04;
  localparam logic [7:0] IDX_TRK_HI = 8'h05;
  localparam logic [7:0] IDX_UNIT = 8'h06;
  localparam logic [7:0] IDX_OPCODE = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] IDX_ERROR = 8'h09;
  localparam logic [7:0] IDX_DATA = 8'h0A;
  localparam logic [7:0] IDX_MULT = 8'h0B;
  localparam logic [7:0] IDX_GEOM = 8'h0C;
  localparam logic [7:0] IDX_MEDIA = 8'h0D;
  localparam logic [7:0] IDX_PWR = 8'h0E;

  // opcodes
  localparam logic [7:0] OP_IDLE_A = 8'h97;
  localparam logic [7:0] OP_IDLE_B = 8'hE3;
  localparam logic [7:0] OP_IDLEI_A = 8'h95;
  localparam logic [7:0] OP_IDLEI_B = 8'hE1;
  localparam logic [7:0] OP_INIT_PARM = 8'h91;
  localparam logic [7:0] OP_RD_BUF = 8'hE4;
  localparam logic [7:0] OP_RD_MULT = 8'hC4;
  localparam logic [7:0] OP_RD_LONG_A = 8'h22;
  localparam logic [7:0] OP_RD_LONG_B = 8'h23;
  localparam logic [7:0] OP_RD_SEC_A = 8'h20;
  localparam logic [7:0] OP_RD_SEC_B = 8'h21;

  // status / error bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_UNC = 6;
  localparam logic [7:0] UNIT_FIXED = 8'hA0;
  localparam int UNIT_LBA = 6;

  // sector geometry
  localparam logic [8:0] WORDS_PER_SEC = 9'd256;
  localparam logic [8:0] LONG_WORDS = 9'd260;
  localparam logic [8:0] SECS_MAX = 9'd256;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int PD_UNIT_MS = 5;
  localparam int PD_UNIT_CYC = PD_UNIT_MS * 1000 * CLK_MHZ;
  localparam int FETCH_CYC = 4;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_BUSY = 6'b000010,
    S_FETCH = 6'b000100,
    S_XFER = 6'b001000,
    S_NEXT = 6'b010000,
    S_DONE = 6'b100000
  } atacx_state_t;

  typedef struct packed {
    logic corr;
    logic uncorr;
  } atacx_media_t;
endpackage

// file: design/atacx_top.sv
/*
 ata idle and read command executor, AXI4-Lite register slave.
 assumes media data and error flags arrive from same-clock logic;
 host polls busy/drq registers and reads data through the data port.
*/
`timescale 1ns/1ps
`default_nettype none
module atacx_top #(
  parameter int PD_UNIT = atacx_pkg::PD_UNIT_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // media side
  input wire logic [15:0] media_word,
  input wire atacx_pkg::atacx_media_t media_err,
  // host signals
  output logic host_irq,
  output logic power_down
);
  atacx_pkg::atacx_state_t st_q;
  logic [7:0] feat_q, cnt_q, sec_q, tlo_q, thi_q, unit_q;
  logic [7:0] err_q, mult_q, spt_q, media_q;
  logic [3:0] maxhead_q;
  logic busy_q, drq_q, errb_q, irq_q, long_q, multi_q, nofetch_q, nodata_q;
  logic [15:0] buf_q [0:259];
  logic [8:0] widx_q, left_q, blk_q, wlim;
  logic [2:0] fcnt_q;
  logic [15:0] pd_cnt_q;
  logic [31:0] pd_tick_q;
  logic pd_en_q, pd_q;
  logic aw_q, w_q;
  logic [7:0] awa_q, ara_idx;
  logic [31:0] wd_q;
  logic wr_go, rd_go, cmd_wr, dat_rd;
  logic [8:0] cnt9;
  logic blk_err_q, stop_q;

  function automatic logic is_op(input logic [7:0] o, input logic [7:0] a,
                                 input logic [7:0] b);
    is_op = (o == a) || (o == b);
  endfunction

  // write channel capture, either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= {2'b00, s_axi_awaddr[7:2]};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign cmd_wr = wr_go && awa_q == atacx_pkg::IDX_OPCODE && !busy_q;
  assign cnt9 = (cnt_q == 8'h00) ? atacx_pkg::SECS_MAX : {1'b0, cnt_q};
  assign wlim = long_q ? atacx_pkg::LONG_WORDS : atacx_pkg::WORDS_PER_SEC;

  // read channel
  assign ara_idx = {2'b00, s_axi_araddr[7:2]};
  assign s_axi_arready = !s_axi_rvalid && !(drq_q && // wait for fetch
    ara_idx == atacx_pkg::IDX_DATA && st_q != atacx_pkg::S_XFER);
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign dat_rd = rd_go && ara_idx == atacx_pkg::IDX_DATA && drq_q;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      case (ara_idx)
        atacx_pkg::IDX_FEATURE: s_axi_rdata <= {24'h0, feat_q};
        atacx_pkg::IDX_COUNT: s_axi_rdata <= {24'h0, cnt_q};
        atacx_pkg::IDX_SECTOR: s_axi_rdata <= {24'h0, sec_q};
        atacx_pkg::IDX_TRK_LO: s_axi_rdata <= {24'h0, tlo_q};
        atacx_pkg::IDX_TRK_HI: s_axi_rdata <= {24'h0, thi_q};
        atacx_pkg::IDX_UNIT: s_axi_rdata <= {24'h0, unit_q};
        atacx_pkg::IDX_STATUS: s_axi_rdata <= {24'h0, busy_q, 3'b000,
                                 drq_q, 2'b00, errb_q};
        atacx_pkg::IDX_ERROR: s_axi_rdata <= {24'h0, err_q};
        atacx_pkg::IDX_DATA: s_axi_rdata <= drq_q ?
          (long_q && widx_q >= atacx_pkg::WORDS_PER_SEC ?
           {24'h0, buf_q[widx_q][7:0]} : {16'h0, buf_q[widx_q]}) :
          32'h0000_0000;
        atacx_pkg::IDX_MULT: s_axi_rdata <= {24'h0, mult_q};
        atacx_pkg::IDX_GEOM: s_axi_rdata <= {20'h0, maxhead_q, spt_q};
        atacx_pkg::IDX_PWR: s_axi_rdata <= {16'h0, pd_cnt_q[13:0],
                                         pd_en_q, pd_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // parameter registers and geometry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feat_q <= 8'h00;
      cnt_q <= 8'h01;
      sec_q <= 8'h01;
      tlo_q <= 8'h00;
      thi_q <= 8'h00;
      unit_q <= atacx_pkg::UNIT_FIXED;
      mult_q <= 8'h00;
      spt_q <= 8'h00;
      maxhead_q <= 4'h0;
      media_q <= 8'h00;
    end else begin
      if (wr_go && !busy_q) begin
        case (awa_q)
          atacx_pkg::IDX_FEATURE: feat_q <= wd_q[7:0];
          atacx_pkg::IDX_COUNT: cnt_q <= wd_q[7:0];
          atacx_pkg::IDX_SECTOR: sec_q <= wd_q[7:0];
          atacx_pkg::IDX_TRK_LO: tlo_q <= wd_q[7:0];
          atacx_pkg::IDX_TRK_HI: thi_q <= wd_q[7:0];
          atacx_pkg::IDX_UNIT: unit_q <= wd_q[7:0] | atacx_pkg::UNIT_FIXED;
          atacx_pkg::IDX_MULT: mult_q <= wd_q[7:0];
          atacx_pkg::IDX_MEDIA: media_q <= wd_q[7:0];
          default: feat_q <= feat_q;
        endcase
      end
      if (cmd_wr && wd_q[7:0] == atacx_pkg::OP_INIT_PARM) begin
        spt_q <= cnt_q;
        maxhead_q <= unit_q[3:0];
      end
      // advance unless an uncorrectable error stopped the read or no sector follows
      if (st_q == atacx_pkg::S_NEXT && !stop_q && left_q != 9'd1) begin
        if (unit_q[atacx_pkg::UNIT_LBA]) begin
          {unit_q[3:0], thi_q, tlo_q, sec_q} <=
            {unit_q[3:0], thi_q, tlo_q, sec_q} + 28'd1;
        end else if (sec_q >= spt_q) begin
          sec_q <= 8'h01;
          if (unit_q[3:0] >= maxhead_q) begin
            unit_q[3:0] <= 4'h0;
            {thi_q, tlo_q} <= {thi_q, tlo_q} + 16'd1;
          end else begin
            unit_q[3:0] <= unit_q[3:0] + 4'h1;
          end
        end else begin
          sec_q <= sec_q + 8'h01;
        end
      end
    end
  end

  // command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= atacx_pkg::S_IDLE;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      errb_q <= 1'b0;
      err_q <= 8'h00;
      irq_q <= 1'b0;
      long_q <= 1'b0;
      multi_q <= 1'b0;
      nofetch_q <= 1'b0;
      nodata_q <= 1'b0;
      widx_q <= 9'd0;
      left_q <= 9'd0;
      blk_q <= 9'd0;
      fcnt_q <= 3'd0;
      blk_err_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (rd_go && ara_idx == atacx_pkg::IDX_STATUS) irq_q <= 1'b0;
      case (st_q)
        atacx_pkg::S_IDLE: begin
          if (cmd_wr) begin
            busy_q <= 1'b1;
            errb_q <= 1'b0;
            err_q <= 8'h00;
            irq_q <= 1'b0;
            stop_q <= 1'b0;
            nodata_q <= 1'b0;
            blk_err_q <= 1'b0;
            long_q <= is_op(wd_q[7:0], atacx_pkg::OP_RD_LONG_A,
                            atacx_pkg::OP_RD_LONG_B);
            multi_q <= wd_q[7:0] == atacx_pkg::OP_RD_MULT;
            nofetch_q <= wd_q[7:0] == atacx_pkg::OP_RD_BUF;
            left_q <= is_op(wd_q[7:0], atacx_pkg::OP_RD_LONG_A,
                            atacx_pkg::OP_RD_LONG_B) ||
                      wd_q[7:0] == atacx_pkg::OP_RD_BUF ? 9'd1 : cnt9;
            st_q <= atacx_pkg::S_BUSY;
          end
        end
        atacx_pkg::S_BUSY: begin
          fcnt_q <= 3'd0;
          widx_q <= 9'd0;
          blk_q <= 9'd0;
          if (multi_q && (mult_q == 8'h00)) begin
            err_q[atacx_pkg::ER_ABRT] <= 1'b1;
            errb_q <= 1'b1;
            st_q <= atacx_pkg::S_DONE;
          end else if (long_q || multi_q || nofetch_q ||
                       st_q == atacx_pkg::S_BUSY && left_q != 9'd0 &&
                       is_op(wd_q[7:0], atacx_pkg::OP_RD_SEC_A,
                             atacx_pkg::OP_RD_SEC_B)) begin
            st_q <= nofetch_q ? atacx_pkg::S_XFER : atacx_pkg::S_FETCH;
            if (nofetch_q) drq_q <= 1'b1;
            if (nofetch_q) irq_q <= 1'b1;
          end else begin
            st_q <= atacx_pkg::S_DONE; // idle, init params, others
            nodata_q <= 1'b1;
          end
        end
        atacx_pkg::S_FETCH: begin
          // load one sector, media error checked unless long
          if (fcnt_q < 3'(atacx_pkg::FETCH_CYC)) begin
            fcnt_q <= fcnt_q + 3'd1;
          end else if (widx_q < wlim) begin
            widx_q <= widx_q + 9'd1;
          end else begin
            widx_q <= 9'd0;
            if (!long_q && (media_err.uncorr || media_err.corr)) begin
              errb_q <= 1'b1;
              err_q[atacx_pkg::ER_UNC] <= media_err.uncorr;
              blk_err_q <= 1'b1;
              if (media_err.uncorr) stop_q <= 1'b1;
            end
            if (!multi_q || blk_q == 9'd0) begin
              drq_q <= 1'b1;
              busy_q <= 1'b0;
              irq_q <= 1'b1;
            end
            st_q <= atacx_pkg::S_XFER;
          end
        end
        atacx_pkg::S_XFER: begin
          busy_q <= 1'b0;
          if (dat_rd) begin
            if (widx_q == wlim - 9'd1) begin
              widx_q <= 9'd0;
              st_q <= atacx_pkg::S_NEXT;
            end else begin
              widx_q <= widx_q + 9'd1;
            end
          end
        end
        atacx_pkg::S_NEXT: begin
          left_q <= left_q - 9'd1;
          fcnt_q <= 3'd0;
          // block boundary at mult_q sectors or end of count
          if (left_q == 9'd1 || (stop_q && !multi_q) ||
              (stop_q && blk_q + 9'd1 == {1'b0, mult_q})) begin
            st_q <= atacx_pkg::S_DONE;
            drq_q <= 1'b0;
          end else if (multi_q && blk_q + 9'd1 < {1'b0, mult_q}) begin
            blk_q <= blk_q + 9'd1; // drq held inside block
            st_q <= atacx_pkg::S_FETCH;
          end else begin
            blk_q <= 9'd0;
            drq_q <= 1'b0;
            busy_q <= 1'b1;
            st_q <= atacx_pkg::S_FETCH;
          end
        end
        atacx_pkg::S_DONE: begin
          busy_q <= 1'b0;
          drq_q <= 1'b0;
          if (nodata_q) irq_q <= 1'b1;
          st_q <= atacx_pkg::S_IDLE;
        end
        default: st_q <= atacx_pkg::S_IDLE;
      endcase
    end
  end

  // sector buffer fill
  always_ff @(posedge aclk) begin
    if (st_q == atacx_pkg::S_FETCH && fcnt_q == 3'(atacx_pkg::FETCH_CYC)
        && widx_q < wlim) begin
      buf_q[widx_q] <= media_word;
    end
  end

  // automatic power-down timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_en_q <= 1'b0;
      pd_cnt_q <= 16'h0000;
      pd_tick_q <= 32'h0000_0000;
      pd_q <= 1'b0;
    end else if (cmd_wr && is_op(wd_q[7:0], atacx_pkg::OP_IDLE_A,
                                 atacx_pkg::OP_IDLE_B)) begin
      pd_en_q <= cnt_q != 8'h00;
      pd_cnt_q <= {8'h00, cnt_q};
      pd_tick_q <= 32'h0000_0000;
      pd_q <= 1'b0;
    end else if (cmd_wr) begin
      pd_q <= 1'b0;
      pd_tick_q <= 32'h0000_0000;
    end else if (pd_en_q && !pd_q && st_q == atacx_pkg::S_IDLE) begin
      if (pd_tick_q == 32'(PD_UNIT) * {16'h0, pd_cnt_q} - 32'd1) pd_q <= 1'b1;
      else pd_tick_q <= pd_tick_q + 32'd1;
    end
  end

  assign host_irq = irq_q;
  assign power_down = pd_q;

  a_idle_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == atacx_pkg::S_DONE && nodata_q
    |=> irq_q && !busy_q)
    else $error("idle completion without interrupt");
  a_zero_nopd: assert property (@(posedge aclk) disable iff (!aresetn)
    !pd_en_q |-> !pd_q)
    else $error("power-down while disabled");
  a_abort_mult: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == atacx_pkg::S_BUSY && multi_q && mult_q == 8'h00
    |=> err_q[atacx_pkg::ER_ABRT] ##1 !drq_q)
    else $error("multiple read not aborted");
  a_drq_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(drq_q) |-> irq_q)
    else $error("drq without interrupt");
  a_drq_nobusy: assert property (@(posedge aclk) disable iff (!aresetn)
    drq_q && st_q == atacx_pkg::S_XFER |-> ##1 !busy_q)
    else $error("busy during transfer");
  a_count_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == atacx_pkg::S_IDLE && cmd_wr && cnt_q == 8'h00 &&
    (is_op(wd_q[7:0], atacx_pkg::OP_RD_SEC_A, atacx_pkg::OP_RD_SEC_B) ||
     wd_q[7:0] == atacx_pkg::OP_RD_MULT)
    |=> left_q == atacx_pkg::SECS_MAX)
    else $error("zero count not 256");
  a_long_one: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == atacx_pkg::S_BUSY && long_q |-> left_q == 9'd1)
    else $error("long read not single sector");
  a_buf_nofetch: assert property (@(posedge aclk) disable iff (!aresetn)
    nofetch_q && st_q != atacx_pkg::S_IDLE |-> st_q != atacx_pkg::S_FETCH)
    else $error("buffer read fetched media");
endmodule
`default_nettype wire

// file: tb/atacx_media_model.sv
/*
 media side partner: a word stream that changes every cycle and
 error flags steered by the bench.
 assumes the same aclk as the executor.
*/
`timescale 1ns/1ps
`default_nettype none
module atacx_media_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // error steering
  input wire logic corr,
  input wire logic uncorr,
  // media side
  output logic [15:0] media_word,
  output atacx_pkg::atacx_media_t media_err
);
  logic [15:0] cnt_q;

  // new pattern each cycle, so a stale word never matches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign media_word = cnt_q ^ 16'hA5C3;
  assign media_err = {corr, uncorr};
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
 bench for atacx_top: axi4-lite tasks and command sequences.
 assumes PD_UNIT shortened to 10 cycles and the media model beside.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ST = atacx_pkg::IDX_STATUS;
  localparam logic [7:0] CT = atacx_pkg::IDX_COUNT;
  localparam logic [7:0] SN = atacx_pkg::IDX_SECTOR;
  localparam logic [7:0] MU = atacx_pkg::IDX_MULT;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic corr = 1'b0;
  logic unc = 1'b0;
  logic awr, wrd, bv, arr, rv, irq, pd;
  logic [1:0] br, rr;
  logic [31:0] rdat, v, w0, wl;
  logic [15:0] mw;
  atacx_pkg::atacx_media_t me;
  logic [7:0] ops [4];
  int fails = 0;
  int num_checks = 0;
  int irqs = 0;
  int k, n;

  always #5 aclk = ~aclk;
  always @(posedge irq) irqs++;

  atacx_top #(.PD_UNIT(10)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry),
    .media_word(mw), .media_err(me), .host_irq(irq), .power_down(pd)
  );

  atacx_media_model media (
    .aclk(aclk), .aresetn(aresetn), .corr(corr), .uncorr(unc),
    .media_word(mw), .media_err(me)
  );

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tmo;
    fails++;
    tally_and_finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    int c;
    bh = 1'b0;
    c = 0;
    @(posedge aclk);
    awa <= {a[5:0], 2'b00};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = awv && awr;
      wh = wv && wrd;
      bh = bv && bry;
      c++;
      if (c > 200) tmo;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic ah, h;
    int c;
    h = 1'b0;
    c = 0;
    @(posedge aclk);
    ara <= {a[5:0], 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    while (!h) begin
      @(negedge aclk);
      ah = arv && arr;
      h = rv && rry;
      q = rdat;
      c++;
      if (c > 400) tmo;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
    end
    rry <= 1'b0;
  endtask

  task automatic wt(input logic [7:0] m, input logic [7:0] e);
    int c;
    c = 0;
    rd(ST, v);
    while ((v[7:0] & m) !== e) begin
      c++;
      if (c > 2000) tmo;
      rd(ST, v);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    wt(8'h80, 8'h00);
    wr(atacx_pkg::IDX_OPCODE, op);
  endtask

  task automatic rdn(input int w);
    for (int i = 0; i < w; i++) begin
      rd(atacx_pkg::IDX_DATA, v);
      if (i == 0) w0 = v;
    end
  endtask

  task automatic blk(input int s);
    wt(8'h88, 8'h08);
    for (int j = 0; j < s; j++) begin
      if (j > 0) begin
        rd(ST, v);
        chk("mid drq", 16'(v[7:0] & 8'h88), 16'h0008);
      end
      rdn(256);
    end
  endtask

  initial begin
    ops = '{atacx_pkg::OP_IDLEI_A, atacx_pkg::OP_IDLEI_B,
            atacx_pkg::OP_IDLE_A, atacx_pkg::OP_IDLE_B};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(SN, 8'h5A);
    rd(SN, v);
    chk("sector reg", v[15:0], 16'h005A);
    rd(8'h3C, v);
    chk("unmapped", v[15:0], 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(CT, 8'h00);
      k = irqs;
      cmd(ops[i]);
      wt(8'h80, 8'h00);
      repeat (3) @(posedge aclk);
      chk("idle irq", 16'(irqs - k), 16'h0001);
    end
    repeat (100) @(posedge aclk);
    chk("pd disabled", 16'(pd), 16'h0000);
    wr(CT, 8'h03);
    cmd(atacx_pkg::OP_IDLE_B);
    wt(8'h80, 8'h00);
    chk("pd early", 16'(pd), 16'h0000);
    n = 0;
    while (!pd && n < 300) begin
      @(posedge aclk);
      n++;
    end
    chk("pd reached", 16'(pd), 16'h0001);
    wr(CT, 8'h08);
    wr(atacx_pkg::IDX_UNIT, 8'hA3);
    cmd(atacx_pkg::OP_INIT_PARM);
    wt(8'h80, 8'h00);
    rd(atacx_pkg::IDX_GEOM, v);
    chk("geometry", {4'h0, v[11:0]}, 16'h0308);
    wr(MU, 8'h00);
    wr(CT, 8'h00);
    cmd(atacx_pkg::OP_RD_MULT);
    wt(8'h80, 8'h00);
    rd(atacx_pkg::IDX_ERROR, v);
    chk("abort", 16'(v[2]), 16'h0001);
    wr(MU, 8'h02);
    wr(CT, 8'h03);
    wr(SN, 8'h10);
    wr(atacx_pkg::IDX_TRK_LO, 8'h00);
    wr(atacx_pkg::IDX_TRK_HI, 8'h00);
    wr(atacx_pkg::IDX_UNIT, 8'hE0);
    k = irqs;
    cmd(atacx_pkg::OP_RD_MULT);
    blk(2);
    blk(1);
    wt(8'h88, 8'h00);
    chk("block irqs", 16'(irqs - k), 16'h0002);
    rd(SN, v);
    chk("last sector", v[15:0], 16'h0012);
    wr(MU, 8'h01);
    wr(CT, 8'h03);
    wr(SN, 8'h20);
    unc <= 1'b1;
    k = irqs;
    cmd(atacx_pkg::OP_RD_MULT);
    wt(8'h88, 8'h08);
    rd(ST, v);
    chk("err at block", 16'(v[0]), 16'h0001);
    rdn(256);
    wt(8'h88, 8'h00);
    chk("stop irqs", 16'(irqs - k), 16'h0001);
    rd(SN, v);
    chk("fail sector", v[15:0], 16'h0020);
    unc <= 1'b0;
    corr <= 1'b1;
    wr(CT, 8'h02);
    wr(SN, 8'h30);
    k = irqs;
    cmd(atacx_pkg::OP_RD_MULT);
    blk(1);
    blk(1);
    wt(8'h88, 8'h00);
    chk("corr irqs", 16'(irqs - k), 16'h0002);
    corr <= 1'b0;
    wr(CT, 8'h02);
    wr(SN, 8'h08);
    wr(atacx_pkg::IDX_TRK_LO, 8'h05);
    wr(atacx_pkg::IDX_UNIT, 8'hA2);
    k = irqs;
    cmd(atacx_pkg::OP_RD_SEC_A);
    blk(1);
    blk(1);
    wt(8'h88, 8'h00);
    chk("sector irqs", 16'(irqs - k), 16'h0002);
    rd(SN, v);
    chk("chs sector", v[15:0], 16'h0001);
    rd(atacx_pkg::IDX_UNIT, v);
    chk("chs head", v[15:0], 16'h00A3);
    rd(atacx_pkg::IDX_TRK_LO, v);
    chk("chs track", v[15:0], 16'h0005);
    for (int i = 0; i < 2; i++) begin
      wr(CT, 8'h05);
      k = irqs;
      cmd(i == 0 ? atacx_pkg::OP_RD_LONG_A : atacx_pkg::OP_RD_LONG_B);
      wt(8'h88, 8'h08);
      chk("long irq", 16'(irqs - k), 16'h0001);
      rdn(260);
      wl = w0;
      chk("ecc byte", 16'(v[15:8]), 16'h0000);
      rd(ST, v);
      chk("one sector", 16'(v[7:0] & 8'h88), 16'h0000);
    end
    k = irqs;
    cmd(atacx_pkg::OP_RD_BUF);
    wt(8'h88, 8'h08);
    chk("buffer irq", 16'(irqs - k), 16'h0001);
    rdn(256);
    chk("buffer word", w0[15:0], wl[15:0]);
    rd(ST, v);
    chk("buffer end", 16'(v[7:0] & 8'h88), 16'h0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
